// ==== reset_cause_flags_regs.vh ====
`ifndef RESET_CAUSE_FLAGS_REGS_VH
`define RESET_CAUSE_FLAGS_REGS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_FLAGS 4'h0
`define OFS_IRQ_STATUS 4'h4
`define OFS_IRQ_MASK 4'h8
`define ADDR_LSB 2
`define ADDR_MSB 3
`define HTRANS_ACTIVE 1
// Decoded register selects
`define SEL_NONE 2'h0
`define SEL_FLAGS 2'h1
`define SEL_STATUS 2'h2
`define SEL_MASK 2'h3
// ****************************************
// Flag register bit positions
// ****************************************
`define FLAGS_MSB 7
`define BIT_PRIO_EN 7
`define BIT_SOFT_RST 4
`define BIT_WDOG_TIMEOUT 3
`define BIT_POWERDOWN 2
`define BIT_POR 1
`define BIT_BROWNOUT 0
`define UNUSED_BITS 2'b00
// Flag reset values after power-on
`define RST_PRIO_EN 1'b0
`define RST_SOFT_RST 1'b1
`define RST_WDOG_TIMEOUT 1'b1
`define RST_POWERDOWN 1'b1
`define RST_POR 1'b0
`define RST_BROWNOUT 1'b0
`define POR_INIT_RST 1'b0
`define POR_INIT_DONE 1'b1
// ****************************************
// Event bits in status and mask
// ****************************************
`define NUM_EVT 4
`define EVT_BROWNOUT 0
`define EVT_WDOG_TIMEOUT 1
`define EVT_SOFT_RESET 2
`define EVT_SLEEP 3
`define NUM_PINS 2
`define PIN_BROWNOUT 0
`define PIN_WDOG 1
`define PIN_IDLE 1'b0
// Misc widths and values
`define ZERO8 8'h00
`define ZERO32 32'h0000_0000
`define ZERO_EVT 4'h0
`endif

// ==== reset_cause_flags.v ====
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "reset_cause_flags_regs.vh"
// Contract
// - Bit 7 is a read/write priority enable, reset to 0, giving two interrupt levels when 1.
// - Bits 6 and 5 always read zero and ignore writes.
// - Bit 4 resets to 1, is cleared when the reset instruction fires, and only firmware sets it.
// - Bit 3 is read-only, set by power-up, watchdog clear or sleep, cleared by a watchdog time-out.
// - Bit 2 is read-only, set by power-up or watchdog clear, cleared by sleep.
// - Bit 1 is cleared by a power-on reset and returns to 1 only by a firmware write.
// - Bit 0 is cleared by a brown-out and stays so until firmware writes it to 1.
// - With brown-out detect enabled, bit 0 reads 1 after a power-on reset.
module reset_cause_flags (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Core events, same clock
  input wire soft_reset_instr,
  input wire watchdog_clear_instr,
  input wire sleep_instr,
  input wire brownout_detect_enable,
  // Asynchronous reset sources
  input wire watchdog_timeout,
  input wire brownout_event,
  // Outputs
  output reg irq_priority_enable,
  output reg irq
);

  // ****************************************
  // Address decode
  // ****************************************
  function [1:0] reg_sel;
    input [`ADDR_MSB:0] a;
    begin
      case (a)
        `OFS_FLAGS: reg_sel = `SEL_FLAGS;
        `OFS_IRQ_STATUS: reg_sel = `SEL_STATUS;
        `OFS_IRQ_MASK: reg_sel = `SEL_MASK;
        default: reg_sel = `SEL_NONE;
      endcase
    end
  endfunction

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  wire [`NUM_PINS-1:0] pin_in;
  wire [`NUM_PINS-1:0] pin_rise;
  // Brown-out on bit 0, watchdog time-out on bit 1
  assign pin_in = {watchdog_timeout, brownout_event};

  genvar g;
  generate
    for (g = 0; g < `NUM_PINS; g = g + 1) begin : g_sync
      reg sync_a;
      reg sync_b;
      reg sync_d;
      // Two stages, then a delay for the rising edge
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync_a <= `PIN_IDLE; // Idle level, no false edge
          sync_b <= `PIN_IDLE;
          sync_d <= `PIN_IDLE;
        end else begin
          sync_a <= pin_in[g];
          sync_b <= sync_a;
          sync_d <= sync_b;
        end
      end
      // Only the second stage feeds logic
      assign pin_rise[g] = sync_b & ~sync_d;
    end
  endgenerate

  wire brownout_hit;
  wire wdog_hit;
  assign brownout_hit = pin_rise[`PIN_BROWNOUT];
  assign wdog_hit = pin_rise[`PIN_WDOG];

  // ****************************************
  // AHB-Lite transfer tracking
  // ****************************************
  wire addr_ok;
  reg wr_pend;
  reg rd_pend;
  reg [1:0] wr_sel;
  reg [1:0] rd_sel;
  // Taken when selected, active and the bus is ready
  assign addr_ok = hsel & htrans[`HTRANS_ACTIVE] & hready;

  // Data phase bookkeeping, selects kept for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_sel <= `SEL_NONE;
      rd_sel <= `SEL_NONE;
    end else begin
      wr_pend <= addr_ok & hwrite;
      rd_pend <= addr_ok & ~hwrite;
      wr_sel <= reg_sel(haddr[`ADDR_MSB:0]);
      rd_sel <= reg_sel(haddr[`ADDR_MSB:0]);
    end
  end

  // Writes take no wait state, reads one
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= ~(addr_ok & ~hwrite);
      hresp <= 1'b0;
    end
  end

  wire wr_flags;
  wire wr_status;
  wire wr_mask;
  // Write strobes for the data phase
  assign wr_flags = wr_pend & (wr_sel == `SEL_FLAGS);
  assign wr_status = wr_pend & (wr_sel == `SEL_STATUS);
  assign wr_mask = wr_pend & (wr_sel == `SEL_MASK);

  // ****************************************
  // Flag write data
  // ****************************************
  wire wr_prio_en;
  wire wr_soft_rst;
  wire wr_por;
  wire wr_brownout;
  // Writable bits of the flag register
  assign wr_prio_en = hwdata[`BIT_PRIO_EN];
  assign wr_soft_rst = hwdata[`BIT_SOFT_RST];
  assign wr_por = hwdata[`BIT_POR];
  assign wr_brownout = hwdata[`BIT_BROWNOUT];

  // ****************************************
  // Reset cause flags
  // ****************************************
  reg soft_reset_flag_n;
  reg watchdog_timeout_flag_n;
  reg powerdown_flag_n;
  reg por_flag_n;
  reg brownout_flag_n;
  reg por_init;

  // Marks the first edge after power-on
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_init <= `POR_INIT_RST;
    end else begin
      por_init <= `POR_INIT_DONE;
    end
  end

  // Priority enable, plain read and write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_priority_enable <= `RST_PRIO_EN;
    end else if (wr_flags) begin
      irq_priority_enable <= wr_prio_en;
    end
  end

  // Reset instruction clears only its own flag, event beats a write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_reset_flag_n <= `RST_SOFT_RST;
    end else if (soft_reset_instr) begin
      soft_reset_flag_n <= 1'b0;
    end else if (wr_flags) begin
      soft_reset_flag_n <= wr_soft_rst;
    end
  end

  // Time-out wins over clear and sleep, no firmware write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_timeout_flag_n <= `RST_WDOG_TIMEOUT;
    end else if (wdog_hit) begin
      watchdog_timeout_flag_n <= 1'b0;
    end else if (watchdog_clear_instr | sleep_instr) begin
      watchdog_timeout_flag_n <= 1'b1;
    end
  end

  // Sleep clears, watchdog clear sets, sleep wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      powerdown_flag_n <= `RST_POWERDOWN;
    end else if (sleep_instr) begin
      powerdown_flag_n <= 1'b0;
    end else if (watchdog_clear_instr) begin
      powerdown_flag_n <= 1'b1;
    end
  end

  // Power-on reset clears it, only firmware sets it again
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_flag_n <= `RST_POR;
    end else if (wr_flags) begin
      por_flag_n <= wr_por;
    end
  end

  // Brown-out flag, armed at power-on when detect is enabled
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brownout_flag_n <= `RST_BROWNOUT;
    end else if (brownout_hit) begin
      brownout_flag_n <= 1'b0;
    end else if (!por_init) begin
      brownout_flag_n <= brownout_detect_enable;
    end else if (wr_flags) begin
      brownout_flag_n <= wr_brownout;
    end
  end

  wire [`FLAGS_MSB:0] flags_value;
  // Unimplemented bits tie to zero
  assign flags_value = {irq_priority_enable, `UNUSED_BITS, soft_reset_flag_n,
    watchdog_timeout_flag_n, powerdown_flag_n, por_flag_n, brownout_flag_n};

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  wire [`NUM_EVT-1:0] evt;
  reg [`NUM_EVT-1:0] irq_status;
  reg [`NUM_EVT-1:0] irq_mask;
  wire [`NUM_EVT-1:0] next_status;
  // One status bit per event source
  assign evt[`EVT_BROWNOUT] = brownout_hit;
  assign evt[`EVT_WDOG_TIMEOUT] = wdog_hit;
  assign evt[`EVT_SOFT_RESET] = soft_reset_instr;
  assign evt[`EVT_SLEEP] = sleep_instr;

  generate
    for (g = 0; g < `NUM_EVT; g = g + 1) begin : g_evt
      // Set wins over write-one-to-clear
      assign next_status[g] = evt[g] | (irq_status[g] & ~(wr_status & hwdata[g]));
    end
  endgenerate

  // Sticky status, loaded from the next value each cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= `ZERO_EVT;
    end else begin
      irq_status <= next_status;
    end
  end

  // Mask, plain read and write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= `ZERO_EVT;
    end else if (wr_mask) begin
      irq_mask <= hwdata[`NUM_EVT-1:0];
    end
  end

  // Level output from the next status, so it rises with the status bit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & (wr_mask ? hwdata[`NUM_EVT-1:0] : irq_mask));
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  reg [31:0] next_rdata;
  // Read mux by the captured select
  always @* begin
    next_rdata = `ZERO32;
    case (rd_sel)
      `SEL_FLAGS: next_rdata[`FLAGS_MSB:0] = flags_value;
      `SEL_STATUS: next_rdata[`NUM_EVT-1:0] = irq_status;
      `SEL_MASK: next_rdata[`NUM_EVT-1:0] = irq_mask;
      default: next_rdata = `ZERO32;
    endcase
  end

  // Loaded in the wait cycle, so a write just before is seen
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `ZERO32;
    end else if (rd_pend) begin
      hrdata <= next_rdata;
    end
  end

endmodule // reset_cause_flags

// ==== flags_asserts.sv ====
`timescale 1ns/1ps
module flags_asserts (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire hreadyout,
  // Flag output
  input wire irq_priority_enable
);
  // ****
  // Transfer checks
  // ****
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Taken requests
  wire tk = hsel && htrans[1] && hready;
  wire f0 = tk && haddr[3:0] == 4'h0;
  rd_wait_a: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout) else $error("rd wait");
  wr_wait_a: assert property (tk && hwrite |=> hreadyout) else $error("wr wait");
  rdy_one_a: assert property (!hreadyout |=> hreadyout) else $error("long wait");
  rdy_cause_a: assert property ($fell(hreadyout) |-> $past(tk && !hwrite)) else $error("odd wait");
  data_hold_a: assert property ($changed(hrdata) |-> $past(!hreadyout)) else $error("data moved");
  unused_zero_a: assert property (hrdata[31:8] == 24'h00_0000 && hrdata[6:5] == 2'h0)
    else $error("unused bits set");
  prio_write_a: assert property ($changed(irq_priority_enable) |->
    $past(f0 && hwrite, 2) && irq_priority_enable == $past(hwdata[7])) else $error("prio");
  prio_read_a: assert property ($rose(hreadyout) && $past(f0, 2) |->
    hrdata[7] == irq_priority_enable) else $error("prio read");
endmodule // flags_asserts
bind reset_cause_flags flags_asserts u_flags_asserts (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .irq_priority_enable);

// ==== reset_cause_flags_bench.sv ====
`timescale 1ns/1ps
module reset_cause_flags_bench;
  // ****
  // Signals
  // ****
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic soft_reset_instr = 1'h0, watchdog_clear_instr = 1'h0, sleep_instr = 1'h0;
  logic brownout_detect_enable = 1'h1, watchdog_timeout = 1'h0, brownout_event = 1'h0;
  logic hreadyout, hresp, irq_priority_enable, irq;
  // One slave, so its ready is the bus ready
  wire hready = hreadyout;
  localparam logic [31:0] FL = 32'h0000_0000, ST = 32'h0000_0004, MK = 32'h0000_0008;
  int err_total = 0, cmp_count = 0;
  always #50 hclk = ~hclk;
  reset_cause_flags u_reset_cause_flags (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .soft_reset_instr,
    .watchdog_clear_instr, .sleep_instr, .brownout_detect_enable, .watchdog_timeout,
    .brownout_event, .irq_priority_enable, .irq);
  // ****
  // Bus tasks
  // ****
  task automatic chk(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Wait for ready, keep read data
  task automatic bus_wait;
    do @(negedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
    @(posedge hclk);
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    bus_wait;
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait;
  endtask
  task automatic rd(input logic [31:0] a, exp);
    xfer(1'h0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_write;
    rd(FL, 32'h0000_001D);
    xfer(1'h1, FL, 32'h0000_00FF);
    rd(FL, 32'h0000_009F);
    chk(irq_priority_enable, 1'h1);
  endtask
  task automatic t_instr;
    sleep_instr <= 1'h1;
    @(posedge hclk);
    sleep_instr <= 1'h0;
    rd(FL, 32'h0000_009B);
    watchdog_clear_instr <= 1'h1;
    @(posedge hclk);
    watchdog_clear_instr <= 1'h0;
    rd(FL, 32'h0000_009F);
    soft_reset_instr <= 1'h1;
    @(posedge hclk);
    soft_reset_instr <= 1'h0;
    rd(FL, 32'h0000_008F);
  endtask
  // Pins held high past the sync delay
  task automatic t_pins;
    watchdog_timeout <= 1'h1;
    repeat (5) @(posedge hclk);
    watchdog_timeout <= 1'h0;
    rd(FL, 32'h0000_0087);
    brownout_event <= 1'h1;
    repeat (5) @(posedge hclk);
    brownout_event <= 1'h0;
    rd(FL, 32'h0000_0086);
    xfer(1'h1, FL, 32'h0000_0001);
    rd(FL, 32'h0000_0005);
    chk(irq_priority_enable, 1'h0);
  endtask
  task automatic t_irq;
    rd(ST, 32'h0000_000F);
    chk(irq, 1'h0);
    xfer(1'h1, MK, 32'h0000_0001);
    repeat (2) @(negedge hclk);
    chk(irq, 1'h1);
    @(posedge hclk);
    xfer(1'h1, ST, 32'h0000_0001);
    repeat (2) @(negedge hclk);
    chk(irq, 1'h0);
    @(posedge hclk);
    rd(ST, 32'h0000_000E);
    rd(MK, 32'h0000_0001);
    xfer(1'h1, 32'h0000_000C, 32'h0000_00FF);
    rd(32'h0000_000C, 32'h0000_0000);
  endtask
  // Mid-run power-on reset with brown-out detect off
  task automatic t_reset;
    xfer(1'h1, FL, 32'h0000_0083);
    rd(FL, 32'h0000_0087);
    brownout_detect_enable <= 1'h0;
    hresetn <= 1'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    chk(irq_priority_enable, 1'h0);
    chk(irq, 1'h0);
    rd(FL, 32'h0000_001C);
    rd(ST, 32'h0000_0000);
    chk(hresp, 1'h0);
  endtask
  task automatic summarize;
    if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence after reset
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    t_write;
    t_instr;
    t_pins;
    t_irq;
    t_reset;
    summarize;
  end
  // Watchdog against a hung bus
  initial begin
    #100_000;
    err_total++;
    summarize;
  end
endmodule // reset_cause_flags_bench
